// ===== logic/flash_status_and_config_regs.sv
/*
 * Status register and persistent configuration register of a serial flash,
 * reached by register commands on the serial link (mode 0, one data line).
 * Assumes chip select stays high at least 8 core clocks between frames and
 * that the host sends whole bytes, most significant bit first.
 */
`timescale 1ns/1ps
module flash_status_and_config_regs
    import flash_regs_pkg::*;
#(
    parameter int unsigned REG_WRITE_CNT = REG_WRITE_CYCLES,
    parameter int unsigned PROGRAM_CNT = PROGRAM_CYCLES,
    parameter int unsigned ERASE_CNT = ERASE_CYCLES
) (
    // core clock, reset and reboot request
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic boot,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dq0,
    output logic dq1_out,
    output logic dq1_oe,
    // write protect pin
    input wire logic wp_n,
    // device state
    output work_cfg_s cfg,
    output logic wip,
    output logic pe_ready,
    output logic wel,
    output logic protect_error,
    output logic array_program,
    output logic array_erase
);

    typedef enum {S_BOOT, S_IDLE, S_BUSY} state_e;

    state_e state;
    op_e op_kind;
    logic [31:0] busy_cnt;
    logic [7:0] status_nv;
    logic [15:0] nvcr;
    frame_s rec;

    // link-side frame state
    logic [2:0] bit_cnt;
    logic [6:0] rx;
    logic op_done;
    logic rd_mode;
    logic rd_nv;
    logic [6:0] tx;
    logic nv_hi;
    logic wip_l1;
    logic wip_l2;

    // core-side synchronisers
    logic [2:0] cs_s;
    logic [2:0] wp_s;
    logic cs_high;
    logic wp_low;

    // byte assembly and read source selection on the link side
    wire [7:0] rx_byte = {rx, dq0};
    wire [3:0] addr_len = cfg.addr_three_byte ? 4'h3 : 4'h4;
    wire [7:0] status_link = {status_nv[7:2], wel, wip_l2};
    wire [7:0] nv_byte = nv_hi ? nvcr[15:8] : nvcr[7:0];
    wire [7:0] tx_load = rd_nv ? nv_byte : status_link;

    // link posedge: bit counting and read-mode decode, cleared per frame
    always_ff @(posedge sclk or posedge cs_n or negedge rst_b) begin
        if (!rst_b || cs_n) begin
            bit_cnt <= 3'h0;
            rx <= 7'h00;
            op_done <= 1'b0;
            rd_mode <= 1'b0;
            rd_nv <= 1'b0;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            rx <= rx_byte[6:0];
            if (bit_cnt == 3'h7 && !op_done) begin
                op_done <= 1'b1;
                rd_mode <= (rx_byte == OPC_READ_STATUS) ||
                           (rx_byte == OPC_READ_PERSIST);
                rd_nv <= rx_byte == OPC_READ_PERSIST;
            end
        end
    end

    // frame record survives chip select so the core can act on it later
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            rec <= '0;
        end else begin
            rec.whole <= bit_cnt == 3'h7;
            if (bit_cnt == 3'h7) begin
                if (!op_done) begin
                    rec.opcode <= rx_byte;
                    rec.nbytes <= 4'h0;
                    rec.addr <= 32'h0;
                end else begin
                    if (rec.nbytes != 4'hf) begin
                        rec.nbytes <= rec.nbytes + 4'h1;
                    end
                    if (rec.nbytes < addr_len) begin
                        rec.addr <= {rec.addr[23:0], rx_byte};
                    end
                    rec.data <= {rec.data[7:0], rx_byte};
                end
            end
        end
    end

    // busy bit into the link domain; the rest of status is quasi-static
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            wip_l1 <= 1'b0;
            wip_l2 <= 1'b0;
        end else begin
            wip_l1 <= wip;
            wip_l2 <= wip_l1;
        end
    end

    // link negedge: shift read data out, released as soon as select rises
    always_ff @(negedge sclk or posedge cs_n or negedge rst_b) begin
        if (!rst_b || cs_n) begin
            tx <= 7'h00;
            nv_hi <= 1'b0;
            dq1_out <= 1'b0;
            dq1_oe <= 1'b0;
        end else begin
            dq1_oe <= rd_mode;
            if (rd_mode && bit_cnt == 3'h0) begin
                // status repeats each byte; config alternates low then high
                tx <= tx_load[6:0];
                dq1_out <= tx_load[7];
                nv_hi <= ~nv_hi;
            end else begin
                tx <= {tx[5:0], 1'b0};
                dq1_out <= tx[6];
            end
        end
    end

    // three-stage synchronisers; a level counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_s <= 3'h7;
            wp_s <= 3'h7;
            cs_high <= 1'b1;
            wp_low <= 1'b0;
        end else begin
            cs_s <= {cs_s[1:0], cs_n};
            wp_s <= {wp_s[1:0], wp_n};
            if (cs_s[1] == cs_s[2]) begin
                cs_high <= cs_s[2];
            end
            if (wp_s[1] == wp_s[2]) begin
                wp_low <= ~wp_s[2];
            end
        end
    end

    // frame end and command decode; the record is frozen while select is high
    wire frame_end = cs_high == 1'b0 && cs_s[1] && cs_s[2];
    wire frame_ok = frame_end && rec.whole;
    wire is_op = frame_ok && rec.nbytes == 4'h0;
    wire do_wren = is_op && rec.opcode == OPC_WRITE_ENABLE;
    wire do_wrdi = is_op && rec.opcode == OPC_WRITE_DISABLE;
    wire do_clear = is_op && rec.opcode == OPC_CLEAR_FLAGS;
    wire sr_locked = status_nv[SR_LOCK_BIT] && wp_low;
    wire do_wrsr = frame_ok && wel && !sr_locked &&
        rec.opcode == OPC_WRITE_STATUS && rec.nbytes == 4'h1;
    wire do_wrnv = frame_ok && wel &&
        rec.opcode == OPC_WRITE_PERSIST && rec.nbytes == 4'h2;
    wire try_prog = frame_ok && wel &&
        rec.opcode == OPC_PROGRAM && rec.nbytes > addr_len;
    wire try_erase = frame_ok && wel &&
        rec.opcode == OPC_ERASE && rec.nbytes == addr_len;

    // protected area from the protect bits and top/bottom select
    wire [3:0] bp = {status_nv[SR_BP3_BIT], status_nv[SR_BP_HI:SR_BP_LO]};
    wire [10:0] prot_cnt = (bp == 4'h0) ? 11'h000 :
        (bp > 4'ha) ? SECTOR_COUNT : 11'(11'h001 << (bp - 4'h1));
    wire [1:0] seg = cfg.segment_low ? 2'h0 : 2'h3;
    wire [25:0] full_addr = cfg.addr_three_byte ?
        {seg, rec.addr[23:0]} : rec.addr[25:0];
    wire [10:0] sector = {1'b0, full_addr[25:SECTOR_LSB]};
    wire prot_hit = status_nv[SR_TB_BIT] ? (sector < prot_cnt) :
        (sector >= SECTOR_COUNT - prot_cnt);
    wire op_blocked = prot_hit && bp != 4'h0;
    wire start_wr = do_wrsr || do_wrnv ||
        ((try_prog || try_erase) && !op_blocked);
    wire prot_fault = (try_prog || try_erase) && op_blocked;
    wire busy_done = busy_cnt == 32'h1;

    // duration chosen by the kind of cycle started
    wire [31:0] start_cnt = do_wrsr || do_wrnv ? 32'(REG_WRITE_CNT) :
        try_prog ? 32'(PROGRAM_CNT) : 32'(ERASE_CNT);
    wire op_e start_kind = do_wrsr ? OP_STATUS : do_wrnv ? OP_PERSIST :
        try_prog ? OP_PROGRAM : OP_ERASE;

    // persistent registers keep their contents across boot requests
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_nv <= SR_NV_RESET;
            nvcr <= NVCR_RESET;
        end else if (state == S_IDLE && !boot) begin
            if (do_wrsr) begin
                status_nv <= {rec.data[7:2], 2'h0};
            end
            if (do_wrnv) begin
                nvcr <= {rec.data[7:0], rec.data[15:8]};
            end
        end
    end

    // working configuration decode from the persistent register
    wire [3:0] dummy_code = nvcr[NV_DUMMY_LSB +: 4];
    wire [3:0] next_dummy = (dummy_code == 4'h0 || dummy_code == 4'hf) ?
        DUMMY_DEFAULT : dummy_code;
    wire quad_en = !nvcr[NV_QUAD_BIT];
    wire dual_en = !nvcr[NV_DUAL_BIT];
    wire proto_e next_proto = quad_en ? PROTO_QUAD :
        dual_en ? PROTO_DUAL : PROTO_EXTENDED;

    // working copy is loaded only at boot, never by a persistent write
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= '0;
        end else if (state == S_BOOT) begin
            cfg.dummy_cycles <= next_dummy;
            cfg.execute_in_place <= nvcr[NV_XIP_LSB +: 3];
            cfg.drive_strength <= nvcr[NV_DRIVE_LSB +: 3];
            cfg.hold_reset_en <= nvcr[NV_HOLD_BIT];
            cfg.protocol <= next_proto;
            cfg.segment_low <= nvcr[NV_SEG_BIT];
            cfg.addr_three_byte <= nvcr[NV_ADDR_BIT];
        end
    end

    // sequencer: boot load, idle decode, timed busy cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_BOOT;
            op_kind <= OP_STATUS;
            busy_cnt <= 32'h0;
        end else if (boot) begin
            state <= S_BOOT;
            busy_cnt <= 32'h0;
        end else begin
            unique case (state)
                S_BOOT: begin
                    state <= S_IDLE;
                end
                S_IDLE: begin
                    if (start_wr) begin
                        state <= S_BUSY;
                        op_kind <= start_kind;
                        busy_cnt <= start_cnt;
                    end
                end
                S_BUSY: begin
                    busy_cnt <= busy_cnt - 32'h1;
                    if (busy_done) begin
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // write enable latch and protection error; commands arriving while busy are ignored
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wel <= 1'b0;
            protect_error <= 1'b0;
        end else if (boot || state == S_BOOT) begin
            wel <= 1'b0;
            protect_error <= 1'b0;
        end else if (state == S_BUSY) begin
            if (busy_done) begin
                wel <= 1'b0;
            end
        end else if (prot_fault) begin
            wel <= 1'b1;
            protect_error <= 1'b1;
        end else if (do_clear) begin
            wel <= 1'b0;
            protect_error <= 1'b0;
        end else if (do_wren) begin
            wel <= 1'b1;
        end else if (do_wrdi && !protect_error) begin
            wel <= 1'b0;
        end
    end

    // busy flags; the inverse flag keeps its own flop so both are registered
    wire next_wip = !boot && ((state == S_IDLE && start_wr) ||
        (state == S_BUSY && !busy_done));
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wip <= 1'b0;
            pe_ready <= 1'b1;
            array_program <= 1'b0;
            array_erase <= 1'b0;
        end else begin
            wip <= next_wip;
            pe_ready <= !next_wip;
            array_program <= next_wip &&
                (state == S_IDLE ? start_kind : op_kind) == OP_PROGRAM;
            array_erase <= next_wip &&
                (state == S_IDLE ? start_kind : op_kind) == OP_ERASE;
        end
    end

endmodule

// ===== logic/flash_regs_pkg.sv
/*
 * Constants, field layouts, timing and carrier types for the flash status
 * and persistent configuration register block.
 * Assumes a single-line serial host in clock mode 0 and a 40 MHz core clock.
 */
package flash_regs_pkg;

    // command opcodes on the serial link
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_READ_STATUS = 8'h05;
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OPC_READ_PERSIST = 8'hb5;
    localparam logic [7:0] OPC_WRITE_PERSIST = 8'hb1;
    localparam logic [7:0] OPC_CLEAR_FLAGS = 8'h50;
    localparam logic [7:0] OPC_PROGRAM = 8'h02;
    localparam logic [7:0] OPC_ERASE = 8'hd8;

    // operation_status field positions
    localparam int SR_LOCK_BIT = 7;
    localparam int SR_BP3_BIT = 6;
    localparam int SR_TB_BIT = 5;
    localparam int SR_BP_HI = 4;
    localparam int SR_BP_LO = 2;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_WIP_BIT = 0;
    localparam logic [7:0] SR_NV_RESET = 8'h00;

    // persistent_configuration field positions
    localparam int NV_DUMMY_LSB = 12;
    localparam int NV_XIP_LSB = 9;
    localparam int NV_DRIVE_LSB = 6;
    localparam int NV_HOLD_BIT = 4;
    localparam int NV_QUAD_BIT = 3;
    localparam int NV_DUAL_BIT = 2;
    localparam int NV_SEG_BIT = 1;
    localparam int NV_ADDR_BIT = 0;
    localparam logic [15:0] NVCR_RESET = 16'hffff;
    localparam logic [3:0] DUMMY_DEFAULT = 4'ha;

    // array geometry: 64 KiB sectors, 1024 of them
    localparam int SECTOR_LSB = 16;
    localparam logic [10:0] SECTOR_COUNT = 11'h400;

    // busy durations and their cycle counts at the core clock
    localparam int CLK_MHZ = 40;
    localparam int T_REG_WRITE_US = 8;
    localparam int T_PROGRAM_US = 500;
    localparam int T_ERASE_MS = 700;
    localparam int REG_WRITE_CYCLES = T_REG_WRITE_US * CLK_MHZ;
    localparam int PROGRAM_CYCLES = T_PROGRAM_US * CLK_MHZ;
    localparam int ERASE_CYCLES = T_ERASE_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {PROTO_EXTENDED, PROTO_DUAL, PROTO_QUAD} proto_e;
    typedef enum logic [1:0] {OP_STATUS, OP_PERSIST, OP_PROGRAM, OP_ERASE} op_e;

    // one captured link frame, stable while chip select is high
    typedef struct packed {
        logic [7:0] opcode;
        logic [3:0] nbytes;
        logic [31:0] addr;
        logic [15:0] data;
        logic whole;
    } frame_s;

    // working configuration loaded at boot
    typedef struct packed {
        logic [3:0] dummy_cycles;
        logic [2:0] execute_in_place;
        logic [2:0] drive_strength;
        logic hold_reset_en;
        proto_e protocol;
        logic segment_low;
        logic addr_three_byte;
    } work_cfg_s;

endpackage

// ===== dv/flash_regs_chk.sv
/*
 * Port checker for the flash status and persistent configuration block.
 * Assumes it is bound to the block and given the same busy counts.
 */
`timescale 1ns/1ps
module flash_regs_chk
    import flash_regs_pkg::*;
#(
    parameter int unsigned REG_WRITE_CNT = 20,
    parameter int unsigned PROGRAM_CNT = 40,
    parameter int unsigned ERASE_CNT = 60
) (
    // clock, reset and reboot
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic boot,
    // link
    input wire logic cs_n,
    input wire logic dq1_oe,
    // device state
    input wire work_cfg_s cfg,
    input wire logic wip,
    input wire logic pe_ready,
    input wire logic wel,
    input wire logic protect_error,
    input wire logic array_program,
    input wire logic array_erase
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    int unsigned busy_cnt;
    logic aborted;
    // busy length counter; a reboot mid-cycle voids the count
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt <= 0;
            aborted <= 1'b0;
        end else begin
            busy_cnt <= wip ? busy_cnt + 1 : 0;
            aborted <= wip && (aborted || boot);
        end
    end
    sequence s_busy_end;
        $fell(wip) && !aborted;
    endsequence
    property p_busy_len;
        s_busy_end |-> busy_cnt == ($past(array_program) ? PROGRAM_CNT :
            $past(array_erase) ? ERASE_CNT : REG_WRITE_CNT);
    endproperty
    property p_ready_inv;
        pe_ready == !wip;
    endproperty
    property p_wel_first;
        $rose(wip) |-> $past(wel);
    endproperty
    property p_wel_clean;
        s_busy_end |-> !wel;
    endproperty
    property p_err_wel;
        protect_error |-> wel;
    endproperty
    property p_err_refuse;
        $rose(protect_error) |-> !wip [*4];
    endproperty
    property p_array_busy;
        (array_program || array_erase) |-> wip;
    endproperty
    property p_cfg_boot;
        !boot [*4] |=> $stable(cfg);
    endproperty
    property p_oe_frame;
        dq1_oe |-> !cs_n;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    a_ready_inv: assert property (p_ready_inv)
        else $error("ready flag not inverse of busy");
    a_wel_first: assert property (p_wel_first)
        else $error("busy began without latch");
    a_wel_clean: assert property (p_wel_clean)
        else $error("latch kept after busy");
    a_err_wel: assert property (p_err_wel)
        else $error("latch lost during error");
    a_err_refuse: assert property (p_err_refuse)
        else $error("protected write ran");
    a_array_busy: assert property (p_array_busy)
        else $error("array op without busy");
    a_cfg_boot: assert property (p_cfg_boot)
        else $error("working config moved without boot");
    a_oe_frame: assert property (p_oe_frame)
        else $error("read line driven outside frame");
endmodule

// ===== dv/spi_host_model.sv
/*
 * Serial host model: mode-0 frames at a 15 ns link clock.
 * Assumes the bench feeds it the resolved read line.
 */
`timescale 1ns/1ps
module spi_host_model (
    // serial link
    output logic sclk,
    output logic cs_n,
    output logic dq0,
    input wire logic dq1,
    // read result
    output logic [63:0] rx_word,
    output logic rx_tog
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        dq0 = 1'b0;
        rx_word = '0;
        rx_tog = 1'b0;
    end
    // whole bytes msb first; clock stands low between frames
    task automatic frame(input int n, input logic [63:0] tx, input bit rd);
        #3 cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            dq0 = tx[i];
            #7.5 sclk = 1'b1;
            rx_word = {rx_word[62:0], dq1};
            #7.5 sclk = 1'b0;
        end
        #7.5 cs_n = 1'b1;
        dq0 = ~dq0; // released line must not keep its last bit
        #250;
        if (rd)
            rx_tog = ~rx_tog;
    endtask
endmodule

// ===== dv/flash_status_and_config_regs_bench.sv
/*
 * Bench for the flash register block: host model, read scoreboard, checks.
 * Assumes the package, checker and host model are compiled first.
 */
`timescale 1ns/1ps
module flash_status_and_config_regs_bench
    import flash_regs_pkg::*;
();
    localparam int unsigned RWC = 60;
    localparam int unsigned PGC = 80;
    localparam int unsigned ERC = 100;
    logic ref_clk, rst_b, boot, wp_n, sclk, cs_n, dq0, dq1_out, dq1_oe;
    logic dq1_w, rx_tog, wip, pe_ready, wel, protect_error;
    logic array_program, array_erase;
    logic pat = 1'b0;
    logic [63:0] rx_word;
    logic [15:0] e, v, old;
    logic [31:0] seed = 32'hb439e8ea;
    logic [15:0] exp_q[$];
    work_cfg_s cfg;
    int error_cnt = 0;
    int checks_done = 0;
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // released read line toggles so a stale bit cannot pass
    always @(posedge ref_clk) pat <= ~pat;
    assign dq1_w = dq1_oe ? dq1_out : pat;
    flash_status_and_config_regs #(
        .REG_WRITE_CNT(RWC), .PROGRAM_CNT(PGC), .ERASE_CNT(ERC)
    ) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .boot(boot), .sclk(sclk),
        .cs_n(cs_n), .dq0(dq0), .dq1_out(dq1_out), .dq1_oe(dq1_oe),
        .wp_n(wp_n), .cfg(cfg), .wip(wip), .pe_ready(pe_ready), .wel(wel),
        .protect_error(protect_error), .array_program(array_program),
        .array_erase(array_erase)
    );
    spi_host_model host (
        .sclk(sclk), .cs_n(cs_n), .dq0(dq0), .dq1(dq1_w),
        .rx_word(rx_word), .rx_tog(rx_tog)
    );
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // working copy expected after boot from a stored value
    function automatic work_cfg_s exp_cfg(input logic [15:0] c);
        work_cfg_s w;
        w.dummy_cycles = (c[15:12] == 4'h0 || c[15:12] == 4'hf) ?
            DUMMY_DEFAULT : c[15:12];
        w.execute_in_place = c[11:9];
        w.drive_strength = c[8:6];
        w.hold_reset_en = c[4];
        w.protocol = !c[3] ? PROTO_QUAD :
            (!c[2] ? PROTO_DUAL : PROTO_EXTENDED);
        w.segment_low = c[1];
        w.addr_three_byte = c[0];
        return w;
    endfunction
    task automatic cmp(input string nm, input logic [31:0] x,
        input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic xf(input int n, input logic [63:0] tx);
        @(negedge ref_clk);
        host.frame(n, tx, 1'b0);
    endtask
    task automatic wr(input int n, input logic [63:0] tx);
        xf(8, OPC_WRITE_ENABLE);
        xf(n, tx);
    endtask
    task automatic rd(input logic [7:0] op, input logic [15:0] x);
        exp_q.push_back(x);
        @(negedge ref_clk);
        host.frame(24, {op, 16'h0}, 1'b1);
    endtask
    task automatic idle();
        for (int i = 0; i < 400 && wip !== 1'b0; i++)
            @(negedge ref_clk);
        cmp("wip", 0, wip);
    endtask
    task automatic reboot();
        @(negedge ref_clk);
        boot = 1'b1;
        @(negedge ref_clk);
        boot = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // scoreboard: each finished read frame takes the oldest note
    always @(rx_tog) begin
        if (exp_q.size() != 0) begin
            e = exp_q.pop_front();
            cmp("read data", e, rx_word[15:0]);
        end
    end
    // a hang far beyond the expected 47 us run counts as a failure
    initial begin
        #500000;
        error_cnt++;
        results();
    end
    initial begin
        rst_b = 1'b0;
        boot = 1'b0;
        wp_n = 1'b1;
        old = 16'hffff;
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        cmp("wel", 0, wel);
        cmp("cfg", 32'(exp_cfg(16'hffff)), 32'(cfg));
        rd(OPC_READ_PERSIST, 16'hffff);
        xf(16, {OPC_WRITE_STATUS, 8'h9c});
        rd(OPC_READ_STATUS, 16'h0000);
        xf(8, OPC_WRITE_ENABLE);
        xf(8, OPC_WRITE_DISABLE);
        cmp("wel", 0, wel);
        xf(16, {OPC_WRITE_STATUS, 8'h9c});
        rd(OPC_READ_STATUS, 16'h0000);
        done("factory");
        wr(16, {OPC_WRITE_STATUS, 8'h9c});
        cmp("ready", 0, pe_ready);
        rd(OPC_READ_STATUS, 16'h9f9f);
        idle();
        rd(OPC_READ_STATUS, 16'h9c9c);
        @(negedge ref_clk) wp_n = 1'b0;
        wr(16, {OPC_WRITE_STATUS, 8'h00});
        rd(OPC_READ_STATUS, 16'h9e9e);
        @(negedge ref_clk) wp_n = 1'b1;
        wr(16, {OPC_WRITE_STATUS, 8'h00});
        idle();
        rd(OPC_READ_STATUS, 16'h0000);
        done("status");
        // bottom then top placement of a one-sector protected area
        for (int t = 1; t >= 0; t--) begin
            wr(16, {OPC_WRITE_STATUS, 2'b00, t[0], 5'b00100});
            idle();
            wr(40, {OPC_PROGRAM, 24'h000010, 8'h5a});
            cmp("error", t[0], protect_error);
            cmp("program", !t[0], array_program);
            idle();
            cmp("wel", t[0], wel);
            // write-disable must not drop the latch while an error stands
            xf(8, OPC_WRITE_DISABLE);
            cmp("wel", t[0], wel);
            xf(8, OPC_CLEAR_FLAGS);
            cmp("error", 0, protect_error);
        end
        wr(32, {OPC_ERASE, 24'h020000});
        cmp("erase", 1, array_erase);
        idle();
        cmp("wel", 0, wel);
        done("protect");
        for (int k = 0; k < 6; k++) begin
            v = k == 0 ? 16'h0000 : (k == 1 ? 16'hfffb : 16'(xs()));
            wr(24, {OPC_WRITE_PERSIST, v[7:0], v[15:8]});
            idle();
            rd(OPC_READ_PERSIST, {v[7:0], v[15:8]});
            cmp("cfg", 32'(exp_cfg(old)), 32'(cfg));
            reboot();
            cmp("cfg", 32'(exp_cfg(v)), 32'(cfg));
            old = v;
        end
        done("config");
        xf(8, OPC_WRITE_ENABLE);
        cmp("wel", 1, wel);
        reboot();
        cmp("wel", 0, wel);
        xf(8, OPC_WRITE_ENABLE);
        @(negedge ref_clk) rst_b = 1'b0;
        repeat (3) @(negedge ref_clk);
        cmp("wel", 0, wel);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd(OPC_READ_PERSIST, 16'hffff);
        done("reset");
        results();
    end
endmodule
bind flash_status_and_config_regs flash_regs_chk #(
    .REG_WRITE_CNT(REG_WRITE_CNT), .PROGRAM_CNT(PROGRAM_CNT),
    .ERASE_CNT(ERASE_CNT)
) u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .boot(boot), .cs_n(cs_n),
    .dq1_oe(dq1_oe), .cfg(cfg), .wip(wip), .pe_ready(pe_ready),
    .wel(wel), .protect_error(protect_error),
    .array_program(array_program), .array_erase(array_erase)
);
